/* include/wdrs_pkg.sv */
package wdrs_pkg;

    // clock and derived timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int BROWNOUT_MIN_WIDTH_NS = 2000;
    localparam int BROWNOUT_MIN_CYCLES = (BROWNOUT_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // firmware-side settle time of the reference, used only by the testbench wait
    localparam int REF_STARTUP_MAX_US = 70;
    localparam int WD_OSC_FREQ_KHZ = 128;

    // register addresses on the i/o port
    localparam int IO_ADDR_W = 6;
    localparam logic [5:0] ADDR_RESET_CAUSE = 6'h00;
    localparam logic [5:0] ADDR_WD_CTRL = 6'h01;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STATUS_POR = 8'h01;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [3:0] STATUS_RESERVED = 4'h0;

    // watchdog timing
    localparam int WD_CNT_W = 21;
    localparam logic [20:0] WD_BASE_CYCLES = 21'h000800;
    localparam logic [3:0] WD_MAX_SEL = 4'h9;
    localparam logic [2:0] CHANGE_WINDOW_CYCLES = 3'h4;

    // fuse coding of a disabled brown-out detector
    localparam logic [1:0] BOD_LEVEL_DISABLED = 2'h3;

    typedef struct packed {
        logic wdIrqFlag;
        logic wdIrqEnable;
        logic prescaleHi;
        logic wdChangeEnable;
        logic wdResetEnable;
        logic [2:0] prescaleLo;
    } wdrs_ctrl_t;

    typedef struct packed {
        logic [3:0] reserved;
        logic watchdogResetFlag;
        logic brownoutResetFlag;
        logic pinResetFlag;
        logic poweronResetFlag;
    } wdrs_status_t;

    typedef enum logic [2:0] {
        SEQ_RUN = 3'b001,
        SEQ_HOLD = 3'b010,
        SEQ_DELAY = 3'b100
    } wdrs_seq_t;

    // reserved codes above the top entry fall back to the longest time-out
    function automatic logic [20:0] wdrs_timeout_cycles(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > WD_MAX_SEL) ? WD_MAX_SEL : sel;
        return WD_BASE_CYCLES << s;
    endfunction

endpackage

/* src/wdrs_sync_filter.sv */
`timescale 1ns/100ps
module wdrs_sync_filter #(
    parameter int FILTER_CYCLES = 0,
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic asyncIn,
    output logic levelOut
);
    logic syncFirstQ;
    logic syncSecondQ;
    logic filtQ;
    logic [15:0] cntQ;

    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncFirstQ <= RESET_LEVEL;
            syncSecondQ <= RESET_LEVEL;
        end else if (ce) begin
            syncFirstQ <= asyncIn;
            syncSecondQ <= syncFirstQ;
        end
    end

    // high level must persist before it is passed; low passes at once
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cntQ <= 16'h0000;
            filtQ <= 1'b0;
        end else if (ce) begin
            if (!syncSecondQ) begin
                cntQ <= 16'h0000;
                filtQ <= 1'b0;
            end else if (cntQ >= 16'(FILTER_CYCLES)) begin
                filtQ <= 1'b1;
            end else begin
                cntQ <= cntQ + 16'h0001;
            end
        end
    end

    assign levelOut = (FILTER_CYCLES == 0) ? syncSecondQ : filtQ;
endmodule

/* src/wdrs_watchdog_reset.sv */
`timescale 1ns/100ps
// Overview of operation
// R1: brown-out holds reset; start-up delay on release
// R2: brown-out needs 2 us below trigger
// R3: watchdog reset pulse one cycle, delay after
// R4: status bits 7..4 read zero
// R5: watchdog flag set on watchdog reset
// R6: brown-out flag set on brown-out reset
// R7: pin flag set on external reset
// R8: power-on flag cleared only by software
// R9: reference on for detector, bandgap or converter
// R10: firmware waits reference start-up before use
// R11: counter runs on 128 kHz oscillator ticks
// R12: restart clears the watchdog counter
// R13: interrupt mode raises wake-capable interrupt
// R14: reset mode produces system reset
// R15: combined mode: interrupt first, then reset
// R16: always-on fuse forces reset mode
// R17: firmware opens change with both bits set
// R18: change accepted only within four cycles
// R19: time-out selectable 16 ms to 8 s
// R20: firmware clears flag and enable at start
// R21: firmware reads then clears reset cause
// R22: prescaler 2048 doubling to 1048576 cycles
// R23: change-enable self-clears after four cycles
// R24: reset-enable reads set while flag set
// R25: irq flag cleared by vector or one
// R26: protected bits frozen outside change window
// R27: prescaler change acts on running count
module wdrs_watchdog_reset #(
    parameter logic [15:0] STARTUP_DELAY_CYCLES = 16'h1000
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    input wire logic [5:0] ioAddr,
    input wire logic ioWrEn,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    input wire logic wdRestart,
    input wire logic irqVectorAck,
    input wire logic wdOscClk,
    input wire logic supplyBelowTrigger,
    input wire logic pinResetN,
    input wire logic wdAlwaysOnFuse,
    input wire logic [1:0] brownoutLevelFuse,
    input wire logic comparatorBandgapSel,
    input wire logic adcEnable,
    output logic wdIrqReq,
    output logic wdResetPulse,
    output logic sysReset,
    output logic refEnable
);
    wdrs_pkg::wdrs_ctrl_t ctrlQ, ctrlD, wrCtrlData, ctrlView;
    wdrs_pkg::wdrs_status_t statusQ, statusD, wrStatusData;
    wdrs_pkg::wdrs_seq_t seqQ, seqD;
    logic [20:0] wdCntQ, wdCntD, wdLimit;
    logic [2:0] winCntQ, winCntD;
    logic [15:0] delayCntQ, delayCntD;
    logic [7:0] rdMux;
    logic oscLevel, oscPrevQ, oscTick;
    logic bodFiltered, bodEnabled, bodActive, bodPrevQ, bodFire;
    logic pinLevelN, pinActive, pinPrevQ, pinFire;
    logic wdeEff, ieEff, wdRunning, expire, expireIrq, expireReset;
    logic wrCtrl, wrStatus, openWrite, changeWrite, sourceActive, refReq;

    // oscillator, supply comparator and reset pin arrive from outside the clock domain
    wdrs_sync_filter #(.FILTER_CYCLES(0), .RESET_LEVEL(1'b0)) u_osc_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .asyncIn(wdOscClk),
        .levelOut(oscLevel)
    );
    wdrs_sync_filter #(.FILTER_CYCLES(wdrs_pkg::BROWNOUT_MIN_CYCLES), .RESET_LEVEL(1'b0)) u_bod_filter (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .asyncIn(supplyBelowTrigger), // [R2]
        .levelOut(bodFiltered)
    );
    wdrs_sync_filter #(.FILTER_CYCLES(0), .RESET_LEVEL(1'b1)) u_pin_sync (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .asyncIn(pinResetN),
        .levelOut(pinLevelN)
    );

    // source decode and edges
    assign oscTick = oscLevel & ~oscPrevQ; // [R11]
    assign bodEnabled = brownoutLevelFuse != wdrs_pkg::BOD_LEVEL_DISABLED;
    assign bodActive = bodEnabled & bodFiltered; // [R1]
    assign bodFire = bodActive & ~bodPrevQ;
    assign pinActive = ~pinLevelN;
    assign pinFire = pinActive & ~pinPrevQ;
    assign refReq = bodEnabled | comparatorBandgapSel | adcEnable; // [R9]

    // effective mode bits; the flag and the fuse override stored bits
    assign wdeEff = ctrlQ.wdResetEnable | statusQ.watchdogResetFlag | wdAlwaysOnFuse; // [R24] [R16]
    assign ieEff = ctrlQ.wdIrqEnable & ~wdAlwaysOnFuse; // [R16]
    assign wdRunning = wdeEff | ieEff;
    assign wdLimit = wdrs_pkg::wdrs_timeout_cycles({ctrlQ.prescaleHi, ctrlQ.prescaleLo}); // [R22] [R19]

    // compare against the live selection, so a shorter one can fire at once
    assign expire = wdRunning & ~sysReset & (wdCntQ >= wdLimit); // [R27]
    assign expireIrq = expire & ieEff & ~(wdeEff & ctrlQ.wdIrqFlag); // [R13] [R15]
    assign expireReset = expire & wdeEff & ~expireIrq; // [R14] [R15]

    // register port decode
    assign wrCtrl = ioWrEn & (ioAddr == wdrs_pkg::ADDR_WD_CTRL);
    assign wrStatus = ioWrEn & (ioAddr == wdrs_pkg::ADDR_RESET_CAUSE);
    assign wrCtrlData = wdrs_pkg::wdrs_ctrl_t'(ioWrData);
    assign wrStatusData = wdrs_pkg::wdrs_status_t'(ioWrData);
    assign openWrite = wrCtrl & wrCtrlData.wdChangeEnable & wrCtrlData.wdResetEnable; // [R17]
    assign changeWrite = wrCtrl & ~wrCtrlData.wdChangeEnable & (winCntQ != 3'h0); // [R18]

    // control register next value; set of the irq flag wins over its clear
    always_comb begin
        ctrlD = ctrlQ;
        winCntD = (winCntQ != 3'h0) ? winCntQ - 3'h1 : 3'h0; // [R23]
        if (sysReset) begin
            ctrlD = wdrs_pkg::wdrs_ctrl_t'(wdrs_pkg::CTRL_RESET);
            winCntD = 3'h0;
        end else begin
            if (wrCtrl) begin
                ctrlD.wdIrqEnable = wrCtrlData.wdIrqEnable;
                if (changeWrite) begin
                    ctrlD.wdResetEnable = wrCtrlData.wdResetEnable; // [R18]
                    ctrlD.prescaleHi = wrCtrlData.prescaleHi;
                    ctrlD.prescaleLo = wrCtrlData.prescaleLo;
                    winCntD = 3'h0;
                end else begin
                    // setting is always allowed, clearing needs the window
                    ctrlD.wdResetEnable = ctrlQ.wdResetEnable | wrCtrlData.wdResetEnable; // [R26]
                    if (openWrite) begin
                        winCntD = wdrs_pkg::CHANGE_WINDOW_CYCLES; // [R18]
                    end
                end
                if (wrCtrlData.wdIrqFlag) begin
                    ctrlD.wdIrqFlag = 1'b0; // [R25]
                end
            end
            if (irqVectorAck) begin
                ctrlD.wdIrqFlag = 1'b0; // [R25]
                if (wdeEff) begin
                    ctrlD.wdIrqEnable = 1'b0; // [R25] [R15]
                end
            end
            if (expireIrq) begin
                ctrlD.wdIrqFlag = 1'b1; // [R13]
            end
        end
        ctrlD.wdChangeEnable = 1'b0;
        ctrlD.wdIrqEnable = ctrlD.wdIrqEnable & ~wdAlwaysOnFuse; // [R16]
    end

    // reset cause: writing zero clears, events in the same cycle win
    always_comb begin
        statusD = statusQ;
        if (wrStatus) begin
            statusD.watchdogResetFlag = statusQ.watchdogResetFlag & wrStatusData.watchdogResetFlag; // [R5]
            statusD.brownoutResetFlag = statusQ.brownoutResetFlag & wrStatusData.brownoutResetFlag; // [R6]
            statusD.pinResetFlag = statusQ.pinResetFlag & wrStatusData.pinResetFlag; // [R7]
            statusD.poweronResetFlag = statusQ.poweronResetFlag & wrStatusData.poweronResetFlag; // [R8]
        end
        statusD.watchdogResetFlag = statusD.watchdogResetFlag | expireReset; // [R5]
        statusD.brownoutResetFlag = statusD.brownoutResetFlag | bodFire; // [R6]
        statusD.pinResetFlag = statusD.pinResetFlag | pinFire; // [R7]
        statusD.reserved = wdrs_pkg::STATUS_RESERVED; // [R4]
    end

    // watchdog count, cleared by restart, expiry or while idle
    always_comb begin
        if (sysReset || !wdRunning || wdRestart || expire) begin
            wdCntD = 21'h000000; // [R12]
        end else if (oscTick) begin
            wdCntD = wdCntQ + 21'h000001; // [R11]
        end else begin
            wdCntD = wdCntQ;
        end
    end

    // reset sequencer; delay starts once every source has gone away
    assign sourceActive = bodActive | pinActive | wdResetPulse;
    always_comb begin
        seqD = seqQ;
        delayCntD = delayCntQ;
        case (seqQ)
            wdrs_pkg::SEQ_RUN: begin
                if (sourceActive) begin
                    seqD = wdrs_pkg::SEQ_HOLD; // [R1]
                end
            end
            wdrs_pkg::SEQ_HOLD: begin
                delayCntD = STARTUP_DELAY_CYCLES;
                if (!sourceActive) begin
                    seqD = wdrs_pkg::SEQ_DELAY; // [R3]
                end
            end
            wdrs_pkg::SEQ_DELAY: begin
                if (sourceActive) begin
                    seqD = wdrs_pkg::SEQ_HOLD;
                end else if (delayCntQ <= 16'h0001) begin
                    seqD = wdrs_pkg::SEQ_RUN; // [R1]
                end else begin
                    delayCntD = delayCntQ - 16'h0001;
                end
            end
            default: begin
                seqD = wdrs_pkg::SEQ_HOLD;
            end
        endcase
    end

    // readback shows effective bits, not the raw stored ones
    always_comb begin
        ctrlView = ctrlQ;
        ctrlView.wdResetEnable = wdeEff; // [R24]
        ctrlView.wdIrqEnable = ieEff;
        ctrlView.wdChangeEnable = winCntQ != 3'h0; // [R23]
    end
    assign rdMux = (ioAddr == wdrs_pkg::ADDR_WD_CTRL) ? ctrlView :
                   (ioAddr == wdrs_pkg::ADDR_RESET_CAUSE) ? statusQ : wdrs_pkg::READ_UNMAPPED;

    // state registers
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrlQ <= wdrs_pkg::wdrs_ctrl_t'(wdrs_pkg::CTRL_RESET);
            statusQ <= wdrs_pkg::wdrs_status_t'(wdrs_pkg::STATUS_POR); // [R8]
            winCntQ <= 3'h0;
            wdCntQ <= 21'h000000;
            seqQ <= wdrs_pkg::SEQ_HOLD;
            delayCntQ <= 16'h0000;
        end else if (ce) begin
            ctrlQ <= ctrlD;
            statusQ <= statusD;
            winCntQ <= winCntD;
            wdCntQ <= wdCntD;
            seqQ <= seqD;
            delayCntQ <= delayCntD;
        end
    end

    // edge memories and registered outputs
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            oscPrevQ <= 1'b0;
            bodPrevQ <= 1'b0;
            pinPrevQ <= 1'b0;
            ioRdData <= 8'h00;
            wdIrqReq <= 1'b0;
            wdResetPulse <= 1'b0;
            sysReset <= 1'b1;
            refEnable <= 1'b0;
        end else if (ce) begin
            oscPrevQ <= oscLevel;
            bodPrevQ <= bodActive;
            pinPrevQ <= pinActive;
            ioRdData <= rdMux;
            wdIrqReq <= ctrlD.wdIrqFlag & ctrlD.wdIrqEnable; // [R13]
            wdResetPulse <= expireReset; // [R3]
            sysReset <= seqD != wdrs_pkg::SEQ_RUN;
            refEnable <= refReq; // [R9]
        end
    end

    // checks, sampled on the core clock
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    a_reserved_read_zero: assert property ((ce && ioAddr == wdrs_pkg::ADDR_RESET_CAUSE) |=> // [R4]
        ioRdData[7:4] == wdrs_pkg::STATUS_RESERVED)
        else $error("reserved status bits read nonzero");
    a_wd_pulse_single: assert property ((ce && wdResetPulse) |=> !wdResetPulse) // [R3]
        else $error("watchdog reset pulse longer than one cycle");
    a_wd_pulse_hold: assert property ((ce && wdResetPulse) |=> sysReset ##0 seqQ == wdrs_pkg::SEQ_HOLD) // [R3]
        else $error("watchdog pulse did not start reset hold");
    a_watchdog_reset_flag_on_expiry: assert property ((ce && expireReset) |=> wdResetPulse && statusQ.watchdogResetFlag) // [R5]
        else $error("watchdog flag not set with reset pulse");
    a_brownout_reset_flag_on_fire: assert property ((ce && bodFire) |=> statusQ.brownoutResetFlag && sysReset) // [R6]
        else $error("brown-out flag or reset missing");
    a_pin_reset_flag_on_fire: assert property ((ce && pinFire) |=> statusQ.pinResetFlag) // [R7]
        else $error("pin reset flag missing");
    a_poweron_reset_flag_sticky: assert property ((ce && statusQ.poweronResetFlag && !wrStatus) |=> statusQ.poweronResetFlag) // [R8]
        else $error("power-on flag cleared without a write");
    a_ref_follows: assert property (ce |=> refEnable == $past(refReq)) // [R9]
        else $error("reference enable does not follow its sources");
    a_restart_clears: assert property ((ce && wdRestart) |=> wdCntQ == 21'h000000) // [R12]
        else $error("restart did not clear the count");
    a_fuse_forces: assert property (wdAlwaysOnFuse |-> wdeEff && !ieEff && !ctrlQ.wdIrqEnable) // [R16]
        else $error("always-on fuse not forcing reset mode");
    a_wde_by_flag: assert property (statusQ.watchdogResetFlag |-> ctrlView.wdResetEnable) // [R24]
        else $error("reset enable reads clear while flag set");
    a_window_closes: assert property ((ce && openWrite && !sysReset) |=> // [R23]
        (winCntQ == wdrs_pkg::CHANGE_WINDOW_CYCLES) ##1 (!ce || winCntQ == 3'h3))
        else $error("change window not four cycles");
    a_protect_hold: assert property ((ce && wrCtrl && winCntQ == 3'h0 && !sysReset) |=> // [R26]
        {ctrlQ.prescaleHi, ctrlQ.prescaleLo} == $past({ctrlQ.prescaleHi, ctrlQ.prescaleLo}))
        else $error("prescaler changed outside the window");
    a_irq_on_expiry: assert property ((ce && expireIrq) |=> ctrlQ.wdIrqFlag && wdIrqReq == ieEff) // [R13]
        else $error("interrupt flag not raised on expiry");
    a_bod_no_glitch: assert property ((ce && $rose(bodFiltered)) |-> $past(supplyBelowTrigger, 3)) // [R2]
        else $error("brown-out passed without a sustained low supply");

    c_wd_reset: cover property (ce && wdResetPulse);
    c_wd_irq: cover property (ce && expireIrq);
    c_change_done: cover property (ce && changeWrite);
    c_brownout: cover property (ce && bodFire);
endmodule

/* tb/wdrs_core_model.sv */
`timescale 1ns/100ps
// firmware side of the core: register writes, restarts, vector entry
module wdrs_core_model (
    input wire logic core_clk,
    output logic [5:0] ioAddr,
    output logic ioWrEn,
    output logic [7:0] ioWrData,
    output logic wdRestart,
    output logic irqVectorAck
);
    initial begin
        ioAddr = 6'h00;
        ioWrEn = 1'b0;
        ioWrData = 8'h00;
        wdRestart = 1'b0;
        irqVectorAck = 1'b0;
    end

    // one write cycle; data inverted afterwards so a stale byte never looks valid
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        ioAddr <= a;
        ioWrData <= d;
        ioWrEn <= 1'b1;
        @(posedge core_clk);
        ioWrEn <= 1'b0;
        ioWrData <= ~d;
    endtask

    // address only; the answer is registered at the next edge
    task automatic rd(input logic [5:0] a);
        @(posedge core_clk);
        ioAddr <= a;
        @(posedge core_clk);
        #1;
    endtask

    // timed change: gap of 2..4 cycles between opening and payload write
    task automatic prot(input logic [7:0] d, input int gap);
        wr(wdrs_pkg::ADDR_WD_CTRL, 8'h18 | (d & 8'h40));
        repeat (gap - 2) @(posedge core_clk);
        wr(wdrs_pkg::ADDR_WD_CTRL, d & 8'hEF);
    endtask

    // restart instruction, one cycle wide
    task automatic restart();
        @(posedge core_clk);
        wdRestart <= 1'b1;
        @(posedge core_clk);
        wdRestart <= 1'b0;
    endtask

    // vector entry of the watchdog interrupt
    task automatic ack();
        @(posedge core_clk);
        irqVectorAck <= 1'b1;
        @(posedge core_clk);
        irqVectorAck <= 1'b0;
    endtask
endmodule

/* tb/tb_wdrs_watchdog_reset.sv */
`timescale 1ns/100ps
module tb_wdrs_watchdog_reset;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic wdOscClk = 1'b0;
    logic supplyBelowTrigger = 1'b0;
    logic pinResetN = 1'b1;
    logic wdAlwaysOnFuse = 1'b0;
    logic [1:0] brownoutLevelFuse = 2'h3;
    logic comparatorBandgapSel = 1'b0;
    logic adcEnable = 1'b0;
    logic [5:0] ioAddr;
    logic ioWrEn, wdRestart, irqVectorAck;
    logic [7:0] ioWrData, ioRdData;
    logic wdIrqReq, wdResetPulse, sysReset, refEnable;
    int n_errors = 0;
    int n_checks = 0;
    int pulseCnt = 0;
    int oscCnt = 0;
    int cycles = 0;
    logic [7:0] expQ[$];
    event rdSeen;

    wdrs_core_model core (.core_clk(core_clk), .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioWrData(ioWrData),
        .wdRestart(wdRestart), .irqVectorAck(irqVectorAck));

    wdrs_watchdog_reset #(.STARTUP_DELAY_CYCLES(16'h0004)) dut (.core_clk(core_clk), .rstn(rstn), .ce(ce),
        .ioAddr(ioAddr), .ioWrEn(ioWrEn), .ioWrData(ioWrData), .ioRdData(ioRdData), .wdRestart(wdRestart),
        .irqVectorAck(irqVectorAck), .wdOscClk(wdOscClk), .supplyBelowTrigger(supplyBelowTrigger),
        .pinResetN(pinResetN), .wdAlwaysOnFuse(wdAlwaysOnFuse), .brownoutLevelFuse(brownoutLevelFuse),
        .comparatorBandgapSel(comparatorBandgapSel), .adcEnable(adcEnable), .wdIrqReq(wdIrqReq),
        .wdResetPulse(wdResetPulse), .sysReset(sysReset), .refEnable(refEnable));

    initial forever #5 core_clk = ~core_clk;

    // fast stand-in for the slow oscillator, phase unrelated to core_clk
    initial begin
        #3;
        forever #30 wdOscClk = ~wdOscClk;
    end

    // osc edge count, reset pulse count and hang guard
    always @(posedge wdOscClk) oscCnt <= oscCnt + 1;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (wdResetPulse === 1'b1) begin
            pulseCnt <= pulseCnt + 1;
        end
        if (cycles == 90000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // expected byte queued before the read; the watcher pops it when data shows
    task automatic chkRd(input logic [5:0] a, input logic [7:0] exp);
        expQ.push_back(exp);
        core.rd(a);
        -> rdSeen;
    endtask

    always begin
        @(rdSeen);
        check(ioRdData, expQ.pop_front(), "register read");
    end

    task automatic waitRun();
        for (int k = 0; k < 400 && sysReset !== 1'b0; k++) begin
            @(posedge core_clk);
            #1;
        end
    endtask

    // bounded wait for interrupt request or reset pulse
    task automatic waitSig(input bit irq, input int lim);
        for (int k = 0; k < lim; k++) begin
            if ((irq ? wdIrqReq : wdResetPulse) === 1'b1) break;
            @(posedge core_clk);
            #1;
        end
    endtask

    initial begin
        int n;
        int base;
        void'($urandom(32'h1513));
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        waitRun();
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h01);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h00);
        core.wr(wdrs_pkg::ADDR_RESET_CAUSE, 8'hFF);
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h01);
        // clock enable low freezes the port, so this clear must not land
        @(posedge core_clk);
        ce <= 1'b0;
        core.wr(wdrs_pkg::ADDR_RESET_CAUSE, 8'h00);
        ce <= 1'b1;
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h01);
        core.wr(wdrs_pkg::ADDR_RESET_CAUSE, 8'h00);
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h00);
        // every combination of the three reference users
        for (int i = 0; i < 8; i++) begin
            @(posedge core_clk);
            brownoutLevelFuse <= i[0] ? 2'h1 : 2'h3;
            comparatorBandgapSel <= i[1];
            adcEnable <= i[2];
            repeat (3) @(posedge core_clk);
            #1;
            check({7'h00, refEnable}, {7'h00, i != 0}, "reference enable");
        end
        // users wait out the reference settle time before trusting results
        repeat (wdrs_pkg::REF_STARTUP_MAX_US * 1000 / wdrs_pkg::CLK_PERIOD_NS) @(posedge core_clk);
        #1;
        check({7'h00, refEnable}, 8'h01, "reference settled");
        // dip shorter than the filter, then a real brown-out
        n = 50 + $urandom % 140;
        @(posedge core_clk);
        supplyBelowTrigger <= 1'b1;
        repeat (n) @(posedge core_clk);
        supplyBelowTrigger <= 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        check({7'h00, sysReset}, 8'h00, "short dip");
        @(posedge core_clk);
        supplyBelowTrigger <= 1'b1;
        repeat (260) @(posedge core_clk);
        #1;
        check({7'h00, sysReset}, 8'h01, "brown-out reset");
        @(posedge core_clk);
        supplyBelowTrigger <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        check({7'h00, sysReset}, 8'h01, "start-up delay");
        waitRun();
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h04);
        @(posedge core_clk);
        pinResetN <= 1'b0;
        repeat (5) @(posedge core_clk);
        #1;
        check({7'h00, sysReset}, 8'h01, "pin reset");
        @(posedge core_clk);
        pinResetN <= 1'b1;
        waitRun();
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h06);
        core.wr(wdrs_pkg::ADDR_RESET_CAUSE, 8'h00);
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h00);
        // change window opens for four cycles only
        core.restart();
        core.wr(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        core.wr(wdrs_pkg::ADDR_WD_CTRL, 8'h18);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h18);
        repeat (4) @(posedge core_clk);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        core.wr(wdrs_pkg::ADDR_WD_CTRL, 8'h00);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        // restarts keep the reset-mode watchdog from firing
        core.restart();
        repeat (1100 + $urandom % 200) @(posedge wdOscClk);
        // keep the restart clear of an oscillator tick still in the synchroniser
        repeat (3) @(posedge core_clk);
        core.restart();
        base = oscCnt;
        repeat (1100 + $urandom % 200) @(posedge wdOscClk);
        #1;
        check(pulseCnt[7:0], 8'h00, "restart held off expiry");
        waitSig(1'b0, 14000);
        check({7'h00, wdResetPulse}, 8'h01, "reset expiry");
        check({7'h00, (oscCnt - base) >= 2048 && (oscCnt - base) <= 2051}, 8'h01, "time-out length");
        @(posedge core_clk);
        #1;
        check({7'h00, wdResetPulse}, 8'h00, "pulse one cycle");
        check({7'h00, sysReset}, 8'h01, "reset with pulse");
        waitRun();
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h08);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        core.restart();
        core.prot(8'h00, 4);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        core.wr(wdrs_pkg::ADDR_RESET_CAUSE, 8'hF7);
        chkRd(wdrs_pkg::ADDR_RESET_CAUSE, 8'h00);
        core.prot(8'h00, 4);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h00);
        // interrupt mode on a long selection, then shrink below the count
        core.restart();
        core.prot(8'h41, 4);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h41);
        repeat (2100) @(posedge wdOscClk);
        #1;
        check({7'h00, wdIrqReq}, 8'h00, "long time-out not reached");
        core.prot(8'h40, 2);
        waitSig(1'b1, 30);
        check({7'h00, wdIrqReq}, 8'h01, "shrunk time-out fires");
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'hC0);
        core.wr(wdrs_pkg::ADDR_WD_CTRL, 8'hC0);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h40);
        // combined mode: interrupt, vector entry, then reset
        core.restart();
        core.prot(8'h48, 2);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h48);
        waitSig(1'b1, 14000);
        check({7'h00, wdIrqReq}, 8'h01, "first expiry interrupts");
        check(pulseCnt[7:0], 8'h01, "no reset on first expiry");
        core.ack();
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        waitSig(1'b0, 14000);
        check({7'h00, wdResetPulse}, 8'h01, "second expiry resets");
        waitRun();
        core.wr(wdrs_pkg::ADDR_RESET_CAUSE, 8'hF7);
        @(posedge core_clk);
        wdAlwaysOnFuse <= 1'b1;
        core.wr(wdrs_pkg::ADDR_WD_CTRL, 8'h40);
        chkRd(wdrs_pkg::ADDR_WD_CTRL, 8'h08);
        wrap_up();
    end
endmodule
